// ### hdl/pchk_pkg.sv
// Package for the processor check detector: check indices, carriers, reset values
package pchk_pkg;
  localparam int PCHK_NUM_CHECKS = 17;
  // Bit positions of the latched check flags
  localparam int CHK_ADDR_HI   = 0;
  localparam int CHK_ADDR_LO   = 1;
  localparam int CHK_BAD_ADDR  = 2;
  localparam int CHK_SDATA     = 3;
  localparam int CHK_CPU_OUT   = 4;
  localparam int CHK_OPMOD_PAR = 5;
  localparam int CHK_BAD_OP    = 6;
  localparam int CHK_CHAN_OUT  = 7;
  localparam int CHK_BAD_Q     = 8;
  localparam int CHK_INBOUND   = 9;
  localparam int CHK_AB        = 10;
  localparam int CHK_ALU       = 11;
  localparam int CHK_LS_HI     = 12;
  localparam int CHK_LS_LO     = 13;
  localparam int CHK_IO_SEL    = 14;
  localparam int CHK_CARRY     = 15;
  localparam int CHK_LS_ANY    = 16;
  localparam logic [PCHK_NUM_CHECKS-1:0] PCHK_FLAGS_RST = 17'h00000;
  localparam logic [2:0] PCHK_LEVEL_RST = 3'h0;
  localparam logic [5:0] PCHK_COND_RST  = 6'h00;
  localparam logic [7:0] PCHK_CS_RST    = 8'h00;

  // Byte with its odd parity bit
  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } pchk_byte_s;

  // Two-byte word, high byte first
  typedef struct packed {
    pchk_byte_s hi;
    pchk_byte_s lo;
  } pchk_word_s;

  // Condition register as shown on the panel
  typedef struct packed {
    logic bin_ovf;
    logic test_false;
    logic dec_ovf;
    logic high;
    logic low;
    logic equal;
  } pchk_cond_s;

  typedef enum logic [1:0] {
    PCHK_RUN,
    PCHK_STOPPED
  } pchk_state_e;
endpackage

// ### hdl/pchk_parity.sv
// Odd parity checker for a byte with its parity bit
module pchk_parity
  import pchk_pkg::*;
(
  input  wire pchk_pkg::pchk_byte_s byte_in,
  output logic                      bad
);
  import pchk_pkg::*;

  // Nine bits must hold an odd count of ones
  assign bad = ~(^{byte_in.par, byte_in.data}); // [RULE20]
endmodule // pchk_parity

// ### hdl/pchk_detector.sv
// Processor check detector: parity and validity checks, latched flags, display
// Overview of operation
// [RULE1] Flag high storage address check on bad parity in address high byte.
// [RULE2] Flag low storage address check on bad parity in address low byte.
// [RULE3] Flag bad address when address exceeds installed storage capacity.
// [RULE4] Flag storage data check when storage data byte has bad parity.
// [RULE5] Flag outbound check when processor drives bad parity toward I/O.
// [RULE6] Flag op/modifier parity check on bad parity in op or Q register.
// [RULE7] Flag bad opcode check when op register holds undefined operation.
// [RULE8] Flag channel outbound check: good parity sent, attachment reports bad.
// [RULE9] Flag bad modifier check when Q byte is invalid for the operation.
// [RULE10] Flag inbound check when inbound bus data carries bad parity.
// [RULE11] Flag operand check when A or B register has bad parity.
// [RULE12] Flag arithmetic unit check when its result has bad parity.
// [RULE13] Flag local storage high check on bad parity in high output byte.
// [RULE14] Flag local storage low check on bad parity in low output byte.
// [RULE15] Flag I/O storage selection check when an attachment selects wrongly.
// [RULE16] Show interrupt level as 3-bit code; level 0 is zero plus cycle light.
// [RULE17] Expose six condition flags: overflows, test false, high, low, equal.
// [RULE18] Expose cycle steal assignment exactly as driven to the channel.
// [RULE19] Check flags stay latched and stop processing until reset or check reset.
// [RULE20] Odd parity per byte, one parity bit on each checked register or bus.
module pchk_detector
  import pchk_pkg::*;
#(
  parameter int ADDR_W   = 16,
  parameter int CS_W     = 8
) (
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  input  wire logic                             check_reset,
  input  wire logic [ADDR_W-1:0]                storage_capacity,
  input  wire pchk_pkg::pchk_word_s             storage_address_reg,
  input  wire logic                             storage_address_valid,
  input  wire pchk_pkg::pchk_byte_s             storage_data_reg,
  input  wire logic                             storage_data_valid,
  input  wire pchk_pkg::pchk_word_s             local_storage_regs,
  input  wire logic                             local_storage_valid,
  input  wire logic                             io_select_request,
  input  wire logic                             io_select_legal,
  input  wire pchk_pkg::pchk_byte_s             opcode_reg,
  input  wire pchk_pkg::pchk_byte_s             modifier_reg,
  input  wire logic                             instr_valid,
  input  wire logic                             opcode_defined,
  input  wire logic                             modifier_allowed,
  input  wire pchk_pkg::pchk_byte_s             operand_a_reg,
  input  wire pchk_pkg::pchk_byte_s             operand_b_reg,
  input  wire logic                             operands_valid,
  input  wire pchk_pkg::pchk_byte_s             arith_logic_unit,
  input  wire logic                             alu_valid,
  input  wire logic                             alu_carry,
  input  wire logic                             alu_carry_expected,
  input  wire pchk_pkg::pchk_byte_s             outbound_bus,
  input  wire logic                             outbound_valid,
  input  wire logic                             io_parity_error,
  input  wire pchk_pkg::pchk_byte_s             inbound_bus,
  input  wire logic                             inbound_valid,
  input  wire logic [2:0]                       interrupt_level_in,
  input  wire logic                             interrupt_active,
  input  wire pchk_pkg::pchk_cond_s             condition_in,
  input  wire logic [CS_W-1:0]                  cycle_steal_in,
  output logic [PCHK_NUM_CHECKS-1:0]            processor_check_flags,
  output logic                                  processor_check,
  output logic                                  processing_stop,
  output logic [2:0]                            interrupt_level_code,
  output logic                                  interrupt_cycle,
  output pchk_pkg::pchk_cond_s                  condition_flags,
  output logic [CS_W-1:0]                       cycle_steal_assignment,
  output logic [CS_W-1:0]                       cycle_steal_display
);
  import pchk_pkg::*;

  localparam int NBYTES = 11;

  logic [PCHK_NUM_CHECKS-1:0] flags_q;
  logic [PCHK_NUM_CHECKS-1:0] flags_d;
  logic [PCHK_NUM_CHECKS-1:0] events;
  pchk_byte_s                 bytes_chk [NBYTES];
  logic [NBYTES-1:0]          bad_par;
  pchk_state_e                state_q;
  logic [2:0]                 level_q;
  logic                       int_cycle_q;
  pchk_cond_s                 cond_q;
  logic [CS_W-1:0]            cs_q;
  logic                       cpu_out_bad;
  logic [ADDR_W-1:0]          address_value;

  // Byte order feeding the parity checkers
  assign bytes_chk[0]  = storage_address_reg.hi;
  assign bytes_chk[1]  = storage_address_reg.lo;
  assign bytes_chk[2]  = storage_data_reg;
  assign bytes_chk[3]  = outbound_bus;
  assign bytes_chk[4]  = opcode_reg;
  assign bytes_chk[5]  = modifier_reg;
  assign bytes_chk[6]  = inbound_bus;
  assign bytes_chk[7]  = operand_a_reg;
  assign bytes_chk[8]  = operand_b_reg;
  assign bytes_chk[9]  = arith_logic_unit;
  assign bytes_chk[10] = local_storage_regs.hi;

  // One checker per byte, plus the local storage low byte below
  for (genvar i = 0; i < NBYTES; i++) begin : g_par
    pchk_parity u_par (
      .byte_in (bytes_chk[i]),
      .bad     (bad_par[i])
    );
  end

  logic ls_lo_bad;
  pchk_parity u_par_ls_lo (
    .byte_in (local_storage_regs.lo),
    .bad     (ls_lo_bad)
  );

  assign address_value = ADDR_W'({storage_address_reg.hi.data, storage_address_reg.lo.data});
  assign cpu_out_bad   = outbound_valid & bad_par[3];

  always_comb begin
    events = '0;
    events[CHK_ADDR_HI]  = storage_address_valid & bad_par[0]; // [RULE1]
    events[CHK_ADDR_LO]  = storage_address_valid & bad_par[1]; // [RULE2]
    // Capacity is the first address past installed storage
    events[CHK_BAD_ADDR] = storage_address_valid
                           & (address_value >= storage_capacity); // [RULE3]
    events[CHK_SDATA]    = storage_data_valid & bad_par[2]; // [RULE4]
    events[CHK_CPU_OUT]  = cpu_out_bad; // [RULE5]
    events[CHK_OPMOD_PAR] = instr_valid & (bad_par[4] | bad_par[5]); // [RULE6]
    // Validity checks only trusted when the byte they judge (op or Q) has good parity
    events[CHK_BAD_OP]   = instr_valid & ~bad_par[4] & ~opcode_defined; // [RULE7]
    // Attachment error counts as channel fault only if we sent good parity
    events[CHK_CHAN_OUT] = outbound_valid & ~bad_par[3] & io_parity_error; // [RULE8]
    events[CHK_BAD_Q]    = instr_valid & ~bad_par[5] & opcode_defined
                           & ~modifier_allowed; // [RULE9]
    events[CHK_INBOUND]  = inbound_valid & bad_par[6]; // [RULE10]
    events[CHK_AB]       = operands_valid & (bad_par[7] | bad_par[8]); // [RULE11]
    events[CHK_ALU]      = alu_valid & bad_par[9]; // [RULE12]
    events[CHK_LS_HI]    = local_storage_valid & bad_par[10]; // [RULE13]
    events[CHK_LS_LO]    = local_storage_valid & ls_lo_bad; // [RULE14]
    events[CHK_IO_SEL]   = io_select_request & ~io_select_legal; // [RULE15]
    events[CHK_CARRY]    = alu_valid & (alu_carry != alu_carry_expected);
    events[CHK_LS_ANY]   = local_storage_valid & (bad_par[10] | ls_lo_bad);
  end

  // New events win over a check reset in the same cycle
  always_comb begin
    flags_d = check_reset ? PCHK_FLAGS_RST : flags_q;
    flags_d = flags_d | events; // [RULE19]
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_q <= PCHK_FLAGS_RST;
    end else begin
      flags_q <= flags_d; // [RULE19]
    end
  end

  // Stop state follows the latched flags
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= PCHK_RUN;
    end else begin
      case (state_q)
        PCHK_RUN: begin
          if (|flags_d) begin
            state_q <= PCHK_STOPPED; // [RULE19]
          end
        end
        PCHK_STOPPED: begin
          if (~|flags_d) begin
            state_q <= PCHK_RUN;
          end
        end
        default: begin
          state_q <= PCHK_RUN;
        end
      endcase
    end
  end

  // Display registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      level_q     <= PCHK_LEVEL_RST;
      int_cycle_q <= 1'b0;
    end else begin
      // Idle shows all bits off; level 0 differs only by the cycle light
      level_q     <= interrupt_active ? interrupt_level_in : PCHK_LEVEL_RST; // [RULE16]
      int_cycle_q <= interrupt_active; // [RULE16]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cond_q <= PCHK_COND_RST;
    end else begin
      cond_q <= condition_in; // [RULE17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs_q <= CS_W'(PCHK_CS_RST);
    end else begin
      cs_q <= cycle_steal_in;
    end
  end

  assign processor_check_flags  = flags_q;
  assign processor_check        = |flags_q;
  assign processing_stop        = (state_q == PCHK_STOPPED);
  assign interrupt_level_code   = level_q;
  assign interrupt_cycle        = int_cycle_q;
  assign condition_flags        = cond_q;
  // Same register feeds channel and display so they can never differ
  assign cycle_steal_assignment = cs_q; // [RULE18]
  assign cycle_steal_display    = cs_q; // [RULE18]
endmodule // pchk_detector

// ### testbench/pchk_detector_chk.sv
// Concurrent checks on the processor check detector ports
module pchk_detector_chk
  import pchk_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int CS_W   = 8
) (
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  input wire logic                   check_reset,
  input wire logic [ADDR_W-1:0]      storage_capacity,
  input wire pchk_pkg::pchk_word_s   storage_address_reg,
  input wire logic                   storage_address_valid,
  input wire pchk_pkg::pchk_byte_s   storage_data_reg,
  input wire logic                   storage_data_valid,
  input wire pchk_pkg::pchk_byte_s   outbound_bus,
  input wire logic                   outbound_valid,
  input wire logic                   io_parity_error,
  input wire logic [2:0]             interrupt_level_in,
  input wire logic                   interrupt_active,
  input wire logic [CS_W-1:0]        cycle_steal_in,
  input wire logic [PCHK_NUM_CHECKS-1:0] processor_check_flags,
  input wire logic                   processor_check,
  input wire logic                   processing_stop,
  input wire logic [2:0]             interrupt_level_code,
  input wire logic                   interrupt_cycle,
  input wire logic [CS_W-1:0]        cycle_steal_assignment,
  input wire logic [CS_W-1:0]        cycle_steal_display
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_sdata; storage_data_valid && !(^storage_data_reg)
    |=> processor_check_flags[CHK_SDATA];
  endproperty
  a_sdata: assert property (p_sdata) else $error("storage data check missed");
  property p_addr; storage_address_valid && ({storage_address_reg.hi.data,
    storage_address_reg.lo.data} >= storage_capacity) |=> processor_check_flags[CHK_BAD_ADDR];
  endproperty
  a_addr: assert property (p_addr) else $error("bad address check missed");
  property p_out; outbound_valid && !(^outbound_bus) |=> processor_check_flags[CHK_CPU_OUT];
  endproperty
  a_out: assert property (p_out) else $error("outbound check missed");
  property p_chan; outbound_valid && (^outbound_bus) && io_parity_error
    |=> processor_check_flags[CHK_CHAN_OUT];
  endproperty
  a_chan: assert property (p_chan) else $error("channel outbound check missed");
  // Set flags may only clear through check reset
  property p_sticky; !check_reset |=> (processor_check_flags
    & $past(processor_check_flags)) == $past(processor_check_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("check flag dropped");
  property p_stop; processing_stop == (|processor_check_flags) && processor_check == processing_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("stop does not follow flags");
  property p_lvl; 1'b1 |=> interrupt_cycle == $past(interrupt_active) && interrupt_level_code
    == ($past(interrupt_active) ? $past(interrupt_level_in) : 3'h0);
  endproperty
  a_lvl: assert property (p_lvl) else $error("interrupt level display wrong");
  property p_cs; 1'b1 |=> cycle_steal_assignment == $past(cycle_steal_in)
    && cycle_steal_display == cycle_steal_assignment;
  endproperty
  a_cs: assert property (p_cs) else $error("cycle steal display wrong");
endmodule // pchk_detector_chk

// ### testbench/pchk_io_model.sv
// Behavioural I/O attachment on the channel side
module pchk_io_model
  import pchk_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           en,
  input  wire logic           bad_par,
  input  wire logic           line_err,
  input  wire logic           bad_sel,
  input  wire pchk_pkg::pchk_byte_s outbound_bus,
  input  wire logic           outbound_valid,
  output pchk_pkg::pchk_byte_s inbound_bus,
  output logic                inbound_valid,
  output logic                io_parity_error,
  output logic                io_select_request,
  output logic                io_select_legal
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  // Data moves every cycle so a stale byte never looks valid
  always @(posedge sys_clk) #1 cnt_q <= cnt_q + 8'h01;
  assign inbound_bus = {~(^cnt_q) ^ bad_par, cnt_q};
  assign inbound_valid = en;
  assign io_parity_error = outbound_valid && (!(^outbound_bus) || line_err);
  assign io_select_request = en;
  assign io_select_legal = ~bad_sel;
endmodule // pchk_io_model

// ### testbench/pchk_detector_tb_top.sv
// Self-checking bench for the processor check detector
module pchk_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pchk_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, check_reset = 1'b0, vld = 1'b0, act = 1'b0;
  logic [17:0] flt = 18'h0;
  logic [2:0] lvl = 3'h0, icode;
  logic [7:0] cs = 8'h00, csa, csd;
  pchk_cond_s cond = 6'h00, cflags;
  pchk_byte_s ib, ob;
  logic ib_v, perr, sreq, slegal, stop, pchk, icyc;
  logic [PCHK_NUM_CHECKS-1:0] flags;
  logic [34:0] rows [23];
  int errors = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  function automatic pchk_byte_s gb(input logic [7:0] d, input logic f);
    return {~(^d) ^ f, d};
  endfunction
  assign ob = gb(8'h3C, flt[4]);
  pchk_detector i_pchk_detector (.sys_clk(sys_clk), .reset_n(reset_n), .check_reset(check_reset),
    .storage_capacity(16'h8000), .storage_address_valid(vld), .storage_address_reg(
    {gb(flt[2] ? 8'h80 : 8'h7F, flt[0]), gb(flt[2] ? 8'h00 : 8'hFF, flt[1])}),
    .storage_data_reg(gb(8'hA5, flt[3])), .storage_data_valid(vld), .local_storage_valid(vld),
    .local_storage_regs({gb(8'h12, flt[12]), gb(8'h34, flt[13])}), .io_select_request(sreq),
    .io_select_legal(slegal), .opcode_reg(gb(8'h5A, flt[5])), .modifier_reg(gb(8'hC3, flt[16])),
    .instr_valid(vld), .opcode_defined(~flt[6]), .modifier_allowed(~flt[8]), .alu_valid(vld),
    .operand_a_reg(gb(8'h81, flt[10])), .operand_b_reg(gb(8'h7E, flt[17])), .operands_valid(vld),
    .arith_logic_unit(gb(8'hF0, flt[11])), .alu_carry(flt[15]), .alu_carry_expected(1'b0),
    .outbound_bus(ob), .outbound_valid(vld), .io_parity_error(perr), .inbound_bus(ib),
    .inbound_valid(ib_v), .interrupt_level_in(lvl), .interrupt_active(act), .condition_in(cond),
    .cycle_steal_in(cs), .processor_check_flags(flags), .processor_check(pchk),
    .processing_stop(stop), .interrupt_level_code(icode), .interrupt_cycle(icyc),
    .condition_flags(cflags), .cycle_steal_assignment(csa), .cycle_steal_display(csd));
  pchk_io_model i_pchk_io_model (.sys_clk(sys_clk), .en(vld), .bad_par(flt[9]),
    .line_err(flt[7]), .bad_sel(flt[14]), .outbound_bus(ob), .outbound_valid(vld),
    .inbound_bus(ib), .inbound_valid(ib_v), .io_parity_error(perr),
    .io_select_request(sreq), .io_select_legal(slegal));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  initial begin
    int e;
    logic [16:0] ex;
    for (int i = 0; i < 19; i++) begin
      e = (i == 16) ? 5 : (i == 17) ? 10 : i;
      ex = (i < 18) ? 17'h1 << e : 17'h0;
      if (i == 12 || i == 13) ex[CHK_LS_ANY] = 1'b1;
      rows[i] = {(i < 18) ? 18'h1 << i : 18'h0, ex};
    end
    // Suppressed checks when parity already failed or the op is undefined, and a combined fault
    rows[19] = {18'h00060, 17'h00020};
    rows[20] = {18'h10100, 17'h00020};
    rows[21] = {18'h00140, 17'h00040};
    rows[22] = {18'h08009, 17'h08009};
    tick(5);
    chk(flags, PCHK_FLAGS_RST);
    chk({icode, icyc, cflags, csa}, {PCHK_LEVEL_RST, 1'b0, PCHK_COND_RST, PCHK_CS_RST});
    reset_n = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      flt = rows[i][34:17];
      vld = 1'b1;
      tick(1);
      vld = 1'b0;
      flt = 18'h0;
      tick(2);
      chk(flags, rows[i][16:0]);
      chk(flags, rows[i][16:0]);
      chk(stop, |rows[i][16:0]);
      check_reset = 1'b1;
      tick(1);
      check_reset = 1'b0;
      chk(flags, 17'h0);
      $display("row %0d done", i);
    end
    flt = 18'h3FFFF;
    tick(2);
    chk(flags, 17'h0);
    // Set must win over a held check reset; every fault is on, dependent checks stay quiet
    {check_reset, vld} = 2'b11;
    tick(1);
    ex = ~((17'h1 << CHK_BAD_OP) | (17'h1 << CHK_CHAN_OUT) | (17'h1 << CHK_BAD_Q));
    chk(flags, ex);
    {flt, vld} = 19'h0;
    tick(1);
    chk(flags, 17'h0);
    check_reset = 1'b0;
    $display("refusal test done");
    for (int k = 0; k < 3; k++) begin
      {lvl, act} = (k == 0) ? 4'hB : (k == 1) ? 4'h1 : 4'h6;
      cond = 6'h2A ^ 6'(k);
      cs = 8'hA5 ^ 8'(k);
      tick(1);
      chk({icode, icyc}, {act ? lvl : 3'h0, act});
      chk({cflags, csa, csd}, {cond, cs, cs});
    end
    $display("display test done");
    {flt[1], vld} = 2'b11;
    tick(1);
    reset_n = 1'b0;
    tick(1);
    chk({flags, stop}, 18'h0);
    chk({icode, icyc, csa}, {PCHK_LEVEL_RST, 1'b0, PCHK_CS_RST});
    {flt, vld} = 19'h0;
    reset_n = 1'b1;
    tick(1);
    chk({flags, stop, csa}, {PCHK_FLAGS_RST, 1'b0, cs});
    $display("mid-run reset test done");
    end_sim();
  end
endmodule // pchk_detector_tb_top
bind pchk_detector pchk_detector_chk #(.ADDR_W(ADDR_W), .CS_W(CS_W)) i_pchk_detector_chk (
  .sys_clk, .reset_n, .check_reset, .storage_capacity, .storage_address_reg,
  .storage_address_valid, .storage_data_reg, .storage_data_valid, .outbound_bus,
  .outbound_valid, .io_parity_error, .interrupt_level_in, .interrupt_active, .cycle_steal_in,
  .processor_check_flags, .processor_check, .processing_stop, .interrupt_level_code,
  .interrupt_cycle, .cycle_steal_assignment, .cycle_steal_display);
